// *** hw/vid_stepper_pkg.sv ***
package vid_stepper_pkg;
  // mode encoding on the mode select pins
  typedef enum logic [1:0]
  {
    stepwise_code_mode = 2'h0,
    slew5_mode = 2'h1,
    slew6_mode = 2'h2
  } dac_mode_t;
  localparam int code_width = 8;
  localparam int sys_clk_khz = 50000;
  localparam int sample_clk_khz = 5500;
  localparam int slew_clk_khz = 345;
  // dividers derived from the clock rates, rounded down
  localparam int sample_div = sys_clk_khz / sample_clk_khz;
  localparam int slew_div = sys_clk_khz / slew_clk_khz;
  localparam logic [3:0] sample_div_last = 4'(sample_div - 1);
  localparam logic [7:0] slew_div_last = 8'(slew_div - 1);
  localparam logic [2:0] normal_qualify = 3'h3;
  localparam logic [2:0] off_qualify = 3'h4;
  localparam logic [code_width-1:0] reset_code = 8'h00;
  // off codes: two for the stepwise table, one for the 5-bit table
  localparam logic [code_width-1:0] off_code_stepwise_a = 8'h00;
  localparam logic [code_width-1:0] off_code_stepwise_b = 8'h01;
  localparam logic [code_width-1:0] off_code_slew5 = 8'h1f;
  localparam logic [code_width-1:0] slew5_mask = 8'h1f;
  localparam logic [code_width-1:0] slew6_mask = 8'h3f;
  // status that travels together to the regulator core
  typedef struct packed
  {
    logic [code_width-1:0] reference_code;
    logic slewing;
    logic latched_off;
  } ref_status_t;
endpackage

// *** hw/dynamic_vid_reference_stepper.sv ***
`timescale 1ns/1ns
module dynamic_vid_reference_stepper
  import vid_stepper_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire dac_mode_t mode,
  input wire logic [code_width-1:0] voltage_select_code,
  input wire logic startup_done,
  input wire logic output_in_window,
  output ref_status_t status,
  output logic regulation_on,
  output logic power_good_flag
);
  // dividers for the sampling and slewing ticks
  logic [3:0] sample_cnt;
  logic sample_tick;
  logic [7:0] slew_cnt;
  logic slew_tick;

  // code qualification
  logic [code_width-1:0] cand;
  logic [2:0] same_cnt;
  logic [code_width-1:0] target;
  logic [code_width-1:0] masked;
  logic is_off;
  logic [2:0] need;
  logic accept;
  logic off_accept;

  // reference, latch and power good state
  logic started;
  logic [code_width-1:0] ref_code;
  logic [code_width-1:0] next_ref_code;
  logic slewing;
  logic latched_off;

  // status bundle is a plain copy of three registers
  assign status = '{
    reference_code: ref_code,
    slewing: slewing,
    latched_off: latched_off};

  // internal sampling tick
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || sample_cnt == sample_div_last)
      sample_cnt <= 4'h0;
    else
      sample_cnt <= sample_cnt + 4'h1;
  end

  // one-cycle strobe at each sampling edge
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      sample_tick <= 1'b0;
    else
      sample_tick <= (sample_cnt == sample_div_last);
  end

  // slew step tick
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || slew_cnt == slew_div_last)
      slew_cnt <= 8'h00;
    else
      slew_cnt <= slew_cnt + 8'h01;
  end

  // one-cycle strobe at each slew step
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      slew_tick <= 1'b0;
    else
      slew_tick <= (slew_cnt == slew_div_last);
  end

  // mask the pins to the width of the active table
  always_comb
  begin
    masked = voltage_select_code;
    unique case (mode)
      stepwise_code_mode:
        masked = voltage_select_code;
      slew5_mode:
        masked = voltage_select_code & slew5_mask;
      slew6_mode:
        masked = voltage_select_code & slew6_mask;
      default:
        masked = voltage_select_code;
    endcase
  end

  // off code detection; the 6-bit table has none
  always_comb
  begin
    is_off = 1'b0;
    unique case (mode)
      stepwise_code_mode:
        is_off = (masked == off_code_stepwise_a) || (masked == off_code_stepwise_b);
      slew5_mode:
        is_off = (masked == off_code_slew5);
      default:
        is_off = 1'b0;
    endcase
  end

  // acceptance at the last needed identical sample
  always_comb
  begin
    need = is_off ? off_qualify : normal_qualify;
    accept = sample_tick && (masked == cand) && (same_cnt == need - 3'h1);
    off_accept = accept && is_off;
  end

  // qualification of sampled codes
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cand <= reset_code;
      same_cnt <= 3'h0;
    end
    else if (sample_tick)
    begin
      if (masked != cand)
      begin
        cand <= masked;
        same_cnt <= 3'h1;
      end
      else if (same_cnt != 3'h7)
        same_cnt <= same_cnt + 3'h1;
    end
  end

  // accepted target code
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      target <= reset_code;
    else if (accept && !is_off)
      target <= cand;
  end

  // next reference: jump in stepwise mode, one code per slow tick otherwise
  always_comb
  begin
    next_ref_code = ref_code;
    if (mode == stepwise_code_mode)
      next_ref_code = target;
    else if (slew_tick && ref_code < target)
      next_ref_code = ref_code + 8'h01;
    else if (slew_tick && ref_code > target)
      next_ref_code = ref_code - 8'h01;
  end

  // reference register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ref_code <= reset_code;
    else
      ref_code <= next_ref_code;
  end

  // slewing flag while the reference trails the target
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      slewing <= 1'b0;
    else
      slewing <= (mode != stepwise_code_mode) && (ref_code != target);
  end

  // off latch, cleared only by reset or enable low
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !enable)
      latched_off <= 1'b0;
    else if (off_accept)
      latched_off <= 1'b1;
  end

  // regulation drops in the same edge that sets the latch
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      regulation_on <= 1'b0;
    else
      regulation_on <= enable && !latched_off && !off_accept;
  end

  // start-up seen since enable last rose
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      started <= 1'b0;
    else
      started <= enable && (started || startup_done);
  end

  // power good, also blocked in the edge that latches off
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      power_good_flag <= 1'b0;
    else
      power_good_flag <= started && enable && !latched_off && !off_accept && output_in_window;
  end
endmodule

// *** tb/vid_stepper_checker.sv ***
`timescale 1ns/1ns
module vid_stepper_checker
  import vid_stepper_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire dac_mode_t mode,
  input wire logic [code_width-1:0] voltage_select_code,
  input wire ref_status_t status,
  input wire logic regulation_on,
  input wire logic power_good_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // a fresh ordinary stepwise code held for 16 cycles after it changes
  sequence new_code_s;
    mode == stepwise_code_mode && !status.latched_off && voltage_select_code > 8'h01
      && $changed(voltage_select_code) ##1 $stable(voltage_select_code)[*8] ##1 $stable(voltage_select_code)[*8];
  endsequence
  latch_hold_a: assert property (status.latched_off && enable |=> status.latched_off)
    else $error("off latch dropped");
  reg_off_a: assert property (status.latched_off |-> !regulation_on)
    else $error("regulating while off");
  power_good_flag_off_a: assert property (status.latched_off |-> !power_good_flag)
    else $error("power good while off");
  off_qualify_a: assert property ($rose(status.latched_off) |-> $past(voltage_select_code, 24) == $past(voltage_select_code))
    else $error("off code taken early");
  slew_step_a: assert property (mode != stepwise_code_mode && $changed(status.reference_code)
    |-> 8'(status.reference_code - $past(status.reference_code)) inside {8'h01, 8'hff})
    else $error("slew step not one code");
  slew_rate_a: assert property (mode != stepwise_code_mode && $changed(status.reference_code)
    |=> $stable(status.reference_code)[*8])
    else $error("slew too fast");
  step_accept_a: assert property (mode == stepwise_code_mode && $changed(status.reference_code)
    |-> status.reference_code == $past(voltage_select_code, 18))
    else $error("code taken before three samples");
  step_follow_a: assert property (new_code_s |-> ##[1:40] status.reference_code == voltage_select_code)
    else $error("stepwise code not followed");
endmodule
bind dynamic_vid_reference_stepper vid_stepper_checker vid_stepper_checker_inst (.sys_clk(sys_clk), .resetn(resetn),
  .enable(enable), .mode(mode), .voltage_select_code(voltage_select_code), .status(status),
  .regulation_on(regulation_on), .power_good_flag(power_good_flag));

// *** tb/vid_source.sv ***
`timescale 1ns/1ns
module vid_source
  import vid_stepper_pkg::*;
(
  input wire logic sys_clk,
  input wire logic jump,
  input wire logic [code_width-1:0] target,
  output logic [code_width-1:0] code
);
  logic [5:0] gap = 6'h00;
  initial code = 8'h10;
  // one code step per 64 cycles, or a direct jump on request
  always @(negedge sys_clk)
  begin
    gap <= gap + 6'h01;
    if (jump)
      code <= target;
    else if (gap == 6'h00 && code != target)
      code <= (code < target) ? code + 8'h01 : code - 8'h01;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import vid_stepper_pkg::*;
  logic sys_clk = 0, resetn = 0, enable = 0, startup_done = 0, output_in_window = 0, jump = 0;
  logic [7:0] target = 8'h10, code;
  dac_mode_t mode = stepwise_code_mode;
  ref_status_t status;
  logic regulation_on, power_good_flag;
  int err_count = 0, cmp_count = 0;
  vid_source vid_source_inst (.sys_clk(sys_clk), .jump(jump), .target(target), .code(code));
  dynamic_vid_reference_stepper dynamic_vid_reference_stepper_inst (.sys_clk(sys_clk), .resetn(resetn),
    .enable(enable), .mode(mode), .voltage_select_code(code), .startup_done(startup_done),
    .output_in_window(output_in_window), .status(status), .regulation_on(regulation_on),
    .power_good_flag(power_good_flag));
  initial forever #10 sys_clk = ~sys_clk;
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // single steps, a multi-step jump and a short glitch
  task t_step;
    enable = 1;
    startup_done = 1;
    output_in_window = 1;
    target = 8'h13;
    cyc(300);
    chk("ref", 8'h13, status.reference_code);
    chk("power_good_flag", 8'h01, 8'(power_good_flag));
    chk("regon", 8'h01, 8'(regulation_on));
    target = 8'h30;
    jump = 1;
    cyc(60);
    chk("jump", 8'h30, status.reference_code);
    target = 8'h31;
    cyc(12);
    target = 8'h30;
    cyc(60);
    chk("glitch", 8'h30, status.reference_code);
    $display("t_step done");
  endtask
  // multi-step change slews one code per slow tick
  task t_slew;
    mode = slew6_mode;
    target = 8'h36;
    cyc(60);
    chk("slewing", 8'h01, 8'(status.slewing));
    chk("midway", 8'h30, status.reference_code);
    cyc(1000);
    chk("slewed", 8'h36, status.reference_code);
    $display("t_slew done");
  endtask
  // off code latches until enable drops
  task t_off;
    mode = stepwise_code_mode;
    target = 8'h00;
    cyc(60);
    chk("off", 8'h01, 8'(status.latched_off));
    chk("reg", 8'h00, 8'(regulation_on));
    chk("pg", 8'h00, 8'(power_good_flag));
    target = 8'h20;
    cyc(60);
    chk("held", 8'h01, 8'(status.latched_off));
    enable = 0;
    cyc(4);
    chk("clear", 8'h00, 8'(status.latched_off));
    $display("t_off done");
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    final_report;
  end
  initial
  begin
    cyc(16);
    resetn = 1;
    t_step;
    t_slew;
    t_off;
    final_report;
  end
endmodule
